// File: design/trig_sync_map.vh
// Register map, field layout, reset values and encodings of the trigger
// synchronisation delay control block.
// Assumes a 32-bit AXI4-Lite register port; each register index occupies
// one aligned word, so the byte address is four times the index.
`ifndef TRIG_SYNC_MAP_VH
`define TRIG_SYNC_MAP_VH

// Bus geometry.
`define AXI_ADDR_W          16
`define AXI_DATA_W          32
`define IDX_W               12
`define IDX_LSB             2
`define IDX_MSB             13
`define ADDR_TOP_LSB        14
`define ADDR_TOP_ZERO       2'h0
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2
`define DATA_ZERO           32'h00000000
`define LANE0_MSB           7

// Register indices, as printed; byte address is index times four.
`define IDX_TRIGGER_LAG     12'hE20
`define IDX_TRIGGER_LAG_HW  12'hE21
`define IDX_SYNC_SCHEME     12'hE24
`define IDX_REUSED_REF      12'hE25
`define IDX_AVERAGER_LAG    12'hE26
`define IDX_GPERIOD_LAG     12'hE27
`define IDX_OSC_LAG         12'hE28
`define IDX_FORCE_SELECT    12'hE30

// Reset values.
`define RST_TRIGGER_LAG     8'h00
`define RST_SYNC_SCHEME     8'h00
`define RST_REUSED_REF      1'h0
`define RST_AVERAGER_LAG    8'h0E
`define RST_GPERIOD_LAG     8'h00
`define RST_OSC_LAG         8'h00
`define RST_FORCE_SELECT    4'h0
`define RST_STEP            8'h00

// Field positions and masks of the scheme control and reused reference registers.
`define SCHEME_MODE_MSB     1
`define SCHEME_MODE_LSB     0
`define SCHEME_AUTO_INCR    2
`define SCHEME_OSC_RST_EN   4
`define SCHEME_WR_MASK      8'h17
`define REUSED_FLAG_BIT     0

// Force-select bit positions.
`define FORCE_GPERIOD_BIT   0
`define FORCE_AVERAGER_BIT  1
`define FORCE_OSC_BIT       2
`define FORCE_TRIGGER_BIT   3
`define FORCE_MSB           3

// Synchronisation scheme encodings.
`define MODE_REFERENCE      2'h0
`define MODE_TRIG_OWN       2'h1
`define MODE_TRIG_REUSED    2'h2
`define MODE_DIRECT         2'h3

// Lag counter constants.
`define LAG_W               8
`define LAG_ZERO            8'h00
`define LAG_ONE             8'h01

`endif

// File: design/strobe_lag_line.v
// One programmable strobe delay: a start pulse yields one output pulse
// lag+1 clock cycles later (lag 0 gives the next cycle).
// Assumes start and lag come from logic on the same clock.
`timescale 1ns/1ps
`include "trig_sync_map.vh"

module strobe_lag_line (
    // Clock and reset.
    input  wire                clock_i,
    input  wire                rst_i,
    // Launch and delay.
    input  wire                start_i,
    input  wire [`LAG_W-1:0]   lag_i,
    // Delayed strobe.
    output reg                 pulse_o
);

reg              busy;
reg [`LAG_W-1:0] count;

////////////////////////////////////////////////////////////////////////////
// A new start restarts the count, so a late trigger replaces a pending one.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        busy    <= 1'b0;
        count   <= `LAG_ZERO;
        pulse_o <= 1'b0;
    end else if (start_i) begin
        busy    <= (lag_i != `LAG_ZERO);
        count   <= lag_i;
        pulse_o <= (lag_i == `LAG_ZERO);
    end else if (busy) begin
        count   <= count - `LAG_ONE;
        busy    <= (count != `LAG_ONE);
        pulse_o <= (count == `LAG_ONE);
    end else begin
        pulse_o <= 1'b0;
    end
end

endmodule

// File: design/trigger_sync_delay_control.v
// Trigger synchronisation delay control: AXI4-Lite register bank plus the
// strobe delay logic it steers, all on the decimator clock.
// Assumes reference and trigger pins are asynchronous, and that the
// hardware-computed lags arrive from logic on the same clock.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "trig_sync_map.vh"

// Notes on behaviour
// - Mode 00 syncs from system reference.
// - 01 own trigger; 10 reference reused as trigger.
// - Mode 11 gives direct pulse mode.
// - Flag bit selects reused reference function.
// - Eight-bit averager lag, reset value 0x0E.
// - Averager strobe launched by trigger, after lag.
// - Separate eight-bit G-period averager lag.
// - Oscillator strobe delayed by eight-bit lag.
// - Force bit 3 uses programmed trigger lag.
// - Force bit 2 uses programmed oscillator lag.
// - Force bit 1 uses programmed averager lag.
// - Force bit 0 uses programmed G lag.
// - Programmable trigger lag common to all paths.
// - Computed trigger lag readable, read-only.
module trigger_sync_delay_control (
    // Clock and reset.
    input  wire                    clock_i,
    input  wire                    rst_i,
    // AXI4-Lite write address and data.
    input  wire [`AXI_ADDR_W-1:0]  s_axi_awaddr_i,
    input  wire                    s_axi_awvalid_i,
    output reg                     s_axi_awready_o,
    input  wire [`AXI_DATA_W-1:0]  s_axi_wdata_i,
    input  wire [3:0]              s_axi_wstrb_i,
    input  wire                    s_axi_wvalid_i,
    output reg                     s_axi_wready_o,
    // AXI4-Lite write response.
    output reg  [1:0]              s_axi_bresp_o,
    output reg                     s_axi_bvalid_o,
    input  wire                    s_axi_bready_i,
    // AXI4-Lite read.
    input  wire [`AXI_ADDR_W-1:0]  s_axi_araddr_i,
    input  wire                    s_axi_arvalid_i,
    output reg                     s_axi_arready_o,
    output reg  [`AXI_DATA_W-1:0]  s_axi_rdata_o,
    output reg  [1:0]              s_axi_rresp_o,
    output reg                     s_axi_rvalid_o,
    input  wire                    s_axi_rready_i,
    // Asynchronous synchronisation pins.
    input  wire                    sysref_i,
    input  wire                    trigger_i,
    // Hardware-computed lags from the decimator pipeline.
    input  wire [`LAG_W-1:0]       hw_trigger_lag_i,
    input  wire [`LAG_W-1:0]       hw_averager_lag_i,
    input  wire [`LAG_W-1:0]       hw_gperiod_lag_i,
    input  wire [`LAG_W-1:0]       hw_oscillator_lag_i,
    // Strobes to the periodic structures.
    output reg                     reference_sync_o,
    output reg                     trigger_pulse_o,
    output reg                     averager_strobe_o,
    output reg                     oscillator_strobe_o,
    output reg                     oscillator_reset_o
);

////////////////////////////////////////////////////////////////////////////
// Register file storage.
reg [`LAG_W-1:0]     trigger_lag;
reg [7:0]            sync_scheme_control;
reg                  reused_reference_flag;
reg [`LAG_W-1:0]     averager_strobe_lag;
reg [`LAG_W-1:0]     averager_gperiod_lag;
reg [`LAG_W-1:0]     oscillator_strobe_lag;
reg [`FORCE_MSB:0]   lag_force_select;
reg [`LAG_W-1:0]     lag_step;

// Bus holding state.
reg                  aw_held;
reg                  w_held;
reg [`IDX_W-1:0]     aw_index;
reg                  aw_top_ok;
reg [7:0]            w_byte;
reg                  w_lane0;

// Pin synchronisers and settled levels.
reg                  ref_s1;
reg                  ref_s2;
reg                  ref_s3;
reg                  ref_level;
reg                  trig_s1;
reg                  trig_s2;
reg                  trig_s3;
reg                  trig_level;

////////////////////////////////////////////////////////////////////////////
// Effective lags: a clear force bit selects the computed value.
wire [`LAG_W-1:0] computed_trigger_lag = hw_trigger_lag_i + lag_step;
wire [`LAG_W-1:0] eff_trigger_lag  = lag_force_select[`FORCE_TRIGGER_BIT] ?
                                     trigger_lag : computed_trigger_lag;
wire [`LAG_W-1:0] eff_osc_lag      = lag_force_select[`FORCE_OSC_BIT] ?
                                     oscillator_strobe_lag : hw_oscillator_lag_i;
wire [`LAG_W-1:0] eff_averager_lag = lag_force_select[`FORCE_AVERAGER_BIT] ?
                                     averager_strobe_lag : hw_averager_lag_i;
wire [`LAG_W-1:0] eff_gperiod_lag  = lag_force_select[`FORCE_GPERIOD_BIT] ?
                                     averager_gperiod_lag : hw_gperiod_lag_i;

wire [1:0] scheme_mode = sync_scheme_control[`SCHEME_MODE_MSB:`SCHEME_MODE_LSB];
wire       auto_incr   = sync_scheme_control[`SCHEME_AUTO_INCR];
wire       osc_rst_en  = sync_scheme_control[`SCHEME_OSC_RST_EN];

////////////////////////////////////////////////////////////////////////////
// Three-stage synchronisers; a level counts once stages two and three agree.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        ref_s1     <= 1'b0;
        ref_s2     <= 1'b0;
        ref_s3     <= 1'b0;
        ref_level  <= 1'b0;
        trig_s1    <= 1'b0;
        trig_s2    <= 1'b0;
        trig_s3    <= 1'b0;
        trig_level <= 1'b0;
    end else begin
        ref_s1     <= sysref_i;
        ref_s2     <= ref_s1;
        ref_s3     <= ref_s2;
        trig_s1    <= trigger_i;
        trig_s2    <= trig_s1;
        trig_s3    <= trig_s2;
        if (ref_s2 == ref_s3) begin
            ref_level <= ref_s3;
        end
        if (trig_s2 == trig_s3) begin
            trig_level <= trig_s3;
        end
    end
end

// Rising edges of the settled levels.
wire ref_edge  = (ref_s2 == ref_s3) && ref_s3 && !ref_level;
wire trig_edge = (trig_s2 == trig_s3) && trig_s3 && !trig_level;

////////////////////////////////////////////////////////////////////////////
// Scheme decode: which pin edge restarts what.
wire sync_req   = ref_edge && ((scheme_mode == `MODE_REFERENCE) ||
                  ((scheme_mode == `MODE_TRIG_REUSED) && !reused_reference_flag));
wire chain_req  = ((scheme_mode == `MODE_TRIG_OWN) && trig_edge) ||
                  ((scheme_mode == `MODE_TRIG_REUSED) && ref_edge &&
                   reused_reference_flag);
wire direct_req = (scheme_mode == `MODE_DIRECT) && trig_edge;

wire trig_done;
wire avg_mid;
wire avg_done;
wire osc_done;

// Common trigger delay ahead of every path.
strobe_lag_line trigger_line (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (chain_req),
    .lag_i   (eff_trigger_lag),
    .pulse_o (trig_done)
);

// Averager strobe: averager lag, then the G-period adjustment.
strobe_lag_line averager_line (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (trig_done),
    .lag_i   (eff_averager_lag),
    .pulse_o (avg_mid)
);

strobe_lag_line gperiod_line (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (avg_mid),
    .lag_i   (eff_gperiod_lag),
    .pulse_o (avg_done)
);

strobe_lag_line oscillator_line (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .start_i (trig_done),
    .lag_i   (eff_osc_lag),
    .pulse_o (osc_done)
);

////////////////////////////////////////////////////////////////////////////
// Registered strobes; direct pulse mode bypasses every delay.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        reference_sync_o    <= 1'b0;
        trigger_pulse_o     <= 1'b0;
        averager_strobe_o   <= 1'b0;
        oscillator_strobe_o <= 1'b0;
        oscillator_reset_o  <= 1'b0;
    end else begin
        reference_sync_o    <= sync_req;
        trigger_pulse_o     <= trig_done | direct_req;
        averager_strobe_o   <= avg_done | direct_req;
        oscillator_strobe_o <= osc_done | direct_req;
        oscillator_reset_o  <= (osc_done | direct_req) & osc_rst_en;
    end
end

// Calibration step: grows by one per launched trigger while auto increment is set.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        lag_step <= `RST_STEP;
    end else if (!auto_incr) begin
        lag_step <= `RST_STEP;
    end else if (chain_req) begin
        lag_step <= lag_step + `LAG_ONE;
    end
end

////////////////////////////////////////////////////////////////////////////
// Write channel: address and data are taken in either order and held.
wire do_write = aw_held && w_held && !s_axi_bvalid_o;
wire wr_hit   = aw_top_ok && (aw_index == `IDX_TRIGGER_LAG || aw_index == `IDX_TRIGGER_LAG_HW ||
                aw_index == `IDX_SYNC_SCHEME || aw_index == `IDX_REUSED_REF ||
                aw_index == `IDX_AVERAGER_LAG || aw_index == `IDX_GPERIOD_LAG ||
                aw_index == `IDX_OSC_LAG || aw_index == `IDX_FORCE_SELECT);

always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o  <= 1'b1;
        s_axi_bvalid_o  <= 1'b0;
        s_axi_bresp_o   <= `RESP_OKAY;
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        aw_index        <= {`IDX_W{1'b0}};
        aw_top_ok       <= 1'b0;
        w_byte          <= 8'h00;
        w_lane0         <= 1'b0;
    end else begin
        if (s_axi_awready_o && s_axi_awvalid_i) begin
            s_axi_awready_o <= 1'b0;
            aw_held         <= 1'b1;
            aw_index        <= s_axi_awaddr_i[`IDX_MSB:`IDX_LSB];
            aw_top_ok       <= (s_axi_awaddr_i[`AXI_ADDR_W-1:`ADDR_TOP_LSB] == `ADDR_TOP_ZERO);
        end
        if (s_axi_wready_o && s_axi_wvalid_i) begin
            s_axi_wready_o <= 1'b0;
            w_held         <= 1'b1;
            w_byte         <= s_axi_wdata_i[`LANE0_MSB:0];
            w_lane0        <= s_axi_wstrb_i[0];
        end
        if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
            aw_held        <= 1'b0;
            w_held         <= 1'b0;
        end
        // Both channels reopen only once the response is accepted.
        if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
        end
    end
end

// Register updates; only byte lane 0 carries data, the rest is ignored.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        trigger_lag           <= `RST_TRIGGER_LAG;
        sync_scheme_control   <= `RST_SYNC_SCHEME;
        reused_reference_flag <= `RST_REUSED_REF;
        averager_strobe_lag   <= `RST_AVERAGER_LAG;
        averager_gperiod_lag  <= `RST_GPERIOD_LAG;
        oscillator_strobe_lag <= `RST_OSC_LAG;
        lag_force_select      <= `RST_FORCE_SELECT;
    end else if (do_write && w_lane0 && aw_top_ok) begin
        case (aw_index)
            `IDX_TRIGGER_LAG:  trigger_lag           <= w_byte;
            `IDX_SYNC_SCHEME:  sync_scheme_control   <= w_byte & `SCHEME_WR_MASK;
            `IDX_REUSED_REF:   reused_reference_flag <= w_byte[`REUSED_FLAG_BIT];
            `IDX_AVERAGER_LAG: averager_strobe_lag   <= w_byte;
            `IDX_GPERIOD_LAG:  averager_gperiod_lag  <= w_byte;
            `IDX_OSC_LAG:      oscillator_strobe_lag <= w_byte;
            `IDX_FORCE_SELECT: lag_force_select      <= w_byte[`FORCE_MSB:0];
            default: begin
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Read decode; reserved bits read as zero and unmapped words answer SLVERR.
reg [`AXI_DATA_W-1:0] rd_value;
reg                   rd_hit;
wire [`IDX_W-1:0]     ar_index  = s_axi_araddr_i[`IDX_MSB:`IDX_LSB];
wire                  ar_top_ok = (s_axi_araddr_i[`AXI_ADDR_W-1:`ADDR_TOP_LSB] == `ADDR_TOP_ZERO);

always @* begin
    rd_value = `DATA_ZERO;
    rd_hit   = ar_top_ok;
    case (ar_index)
        `IDX_TRIGGER_LAG:    rd_value[`LAG_W-1:0] = trigger_lag;
        `IDX_TRIGGER_LAG_HW: rd_value[`LAG_W-1:0] = computed_trigger_lag;
        `IDX_SYNC_SCHEME:    rd_value[7:0]        = sync_scheme_control;
        `IDX_REUSED_REF:     rd_value[`REUSED_FLAG_BIT] = reused_reference_flag;
        `IDX_AVERAGER_LAG:   rd_value[`LAG_W-1:0] = averager_strobe_lag;
        `IDX_GPERIOD_LAG:    rd_value[`LAG_W-1:0] = averager_gperiod_lag;
        `IDX_OSC_LAG:        rd_value[`LAG_W-1:0] = oscillator_strobe_lag;
        `IDX_FORCE_SELECT:   rd_value[`FORCE_MSB:0] = lag_force_select;
        default:             rd_hit = 1'b0;
    endcase
    if (!rd_hit) begin
        rd_value = `DATA_ZERO;
    end
end

// Read channel: data is captured at the address handshake.
always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
        s_axi_arready_o <= 1'b1;
        s_axi_rvalid_o  <= 1'b0;
        s_axi_rdata_o   <= `DATA_ZERO;
        s_axi_rresp_o   <= `RESP_OKAY;
    end else if (s_axi_arready_o && s_axi_arvalid_i) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o  <= 1'b1;
        s_axi_rdata_o   <= rd_value;
        s_axi_rresp_o   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
    end
end

endmodule

// File: tb/trig_sync_checker_assertions.sv
// Concurrent checks on the ports of the trigger synchronisation block.
// Assumes one clock and the active-high asynchronous reset of the design.
`timescale 1ns/1ps
`include "trig_sync_map.vh"

module trig_sync_checker (
    // Clock and reset.
    input wire                   clock_i,
    input wire                   rst_i,
    // Register bus.
    input wire                   s_axi_awvalid_i,
    input wire                   s_axi_awready_o,
    input wire                   s_axi_wvalid_i,
    input wire                   s_axi_wready_o,
    input wire [1:0]             s_axi_bresp_o,
    input wire                   s_axi_bvalid_o,
    input wire                   s_axi_bready_i,
    input wire [`AXI_ADDR_W-1:0] s_axi_araddr_i,
    input wire                   s_axi_arvalid_i,
    input wire                   s_axi_arready_o,
    input wire [`AXI_DATA_W-1:0] s_axi_rdata_o,
    input wire [1:0]             s_axi_rresp_o,
    input wire                   s_axi_rvalid_o,
    input wire                   s_axi_rready_i,
    // Strobes.
    input wire                   trigger_pulse_o,
    input wire                   averager_strobe_o,
    input wire                   oscillator_strobe_o,
    input wire                   oscillator_reset_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////
    // Cycles since the last delayed trigger; it saturates so it never wraps.
    reg [9:0] since_trig;
    always @(posedge clock_i or posedge rst_i) begin
        if (rst_i)
            since_trig <= 10'h3FF;
        else if (trigger_pulse_o)
            since_trig <= 10'h001;
        else if (since_trig != 10'h3FF)
            since_trig <= since_trig + 10'h001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Handshake steps of the register bus.
    sequence wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence ar_take;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence

    // The held flags are set at the take and the response follows one edge later.
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid_o)
        else $error("write response missing");
    bresp_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
        s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    write_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during response");
    read_answer_a: assert property (ar_take |=> s_axi_rvalid_o)
        else $error("read response missing");
    rdata_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
        s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data changed while waiting");
    read_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
        else $error("read taken during response");
    unmapped_read_a: assert property (ar_take ##0 (s_axi_araddr_i[15:14] != 2'h0) |=>
        s_axi_rresp_o == `RESP_SLVERR && s_axi_rdata_o == `DATA_ZERO)
        else $error("out of range read not refused");
    trigger_single_a: assert property (trigger_pulse_o |=> !trigger_pulse_o)
        else $error("trigger pulse longer than one cycle");
    averager_after_a: assert property (averager_strobe_o |-> trigger_pulse_o || since_trig <= 10'h200)
        else $error("averager strobe without trigger");
    osc_after_a: assert property (oscillator_strobe_o |-> trigger_pulse_o || since_trig <= 10'h100)
        else $error("oscillator strobe without trigger");
    osc_reset_gate_a: assert property (oscillator_reset_o |-> oscillator_strobe_o)
        else $error("oscillator reset without strobe");
endmodule

bind trigger_sync_delay_control trig_sync_checker trig_sync_checker_inst (.*);

// File: tb/testbench.sv
// Self-checking bench for the trigger synchronisation delay control block.
// Assumes the design header is on the include path and the checker is bound.
`timescale 1ns/1ps
`include "trig_sync_map.vh"

module testbench;
    reg         clock_i, rst_i, sysref_i, trigger_i;
    reg  [15:0] s_axi_awaddr_i, s_axi_araddr_i;
    reg  [31:0] s_axi_wdata_i;
    reg  [3:0]  s_axi_wstrb_i;
    reg         s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
    reg  [7:0]  hw_trigger_lag_i, hw_averager_lag_i, hw_gperiod_lag_i, hw_oscillator_lag_i;
    wire        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    wire [1:0]  s_axi_bresp_o, s_axi_rresp_o;
    wire [31:0] s_axi_rdata_o;
    wire        reference_sync_o, trigger_pulse_o, averager_strobe_o, oscillator_strobe_o, oscillator_reset_o;
    int         mismatches, n_checks, cyc, t_trig, t_pin, n_ref, n_trg, n_rst, d0, i;
    reg  [1:0]  qb[$];
    reg  [33:0] qr[$];
    int         qa[$], qo[$];
    reg  [7:0]  lag [0:3];
    reg  [31:0] d;
    reg  [11:0] tix [0:6] = '{12'hE20, 12'hE24, 12'hE25, 12'hE26, 12'hE27, 12'hE28, 12'hE30};
    reg  [7:0]  tmk [0:6] = '{8'hFF, 8'h17, 8'h01, 8'hFF, 8'hFF, 8'hFF, 8'h0F};

    trigger_sync_delay_control trigger_sync_delay_control_inst (.*);

    ////////////////////////////////////////////////////////////////////////
    // Free-running 40 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    // Counts comparisons and reports any difference at once.
    task automatic chk(input string n, input [31:0] s, input [31:0] x);
        n_checks++;
        if (s !== x) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask

    // Prints the verdict; the only place the run ends.
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    function [15:0] ba(input [11:0] x);
        ba = {2'h0, x, 2'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus write: address and data offered together, each dropped once taken.
    task automatic wr(input [15:0] a, input [31:0] x, input [1:0] r);
        qb.push_back(r);
        @(posedge clock_i);
        s_axi_awaddr_i <= a; s_axi_wdata_i <= x; s_axi_awvalid_i <= 1'b1; s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
            if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
        end while (!s_axi_bvalid_o);
        s_axi_bready_i <= 1'b0;
    endtask

    // Bus read; the expected word and response are noted for the monitor.
    task automatic rd(input [15:0] a, input [31:0] x, input [1:0] r);
        qr.push_back({r, x});
        @(posedge clock_i);
        s_axi_araddr_i <= a; s_axi_arvalid_i <= 1'b1; s_axi_rready_i <= 1'b1;
        do begin
            @(posedge clock_i);
            if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
        end while (!s_axi_rvalid_o);
        s_axi_rready_i <= 1'b0;
    endtask

    // Pin pulse long enough to pass the synchroniser, then time for the strobes.
    task automatic pulse(input bit s);
        @(posedge clock_i);
        {sysref_i, trigger_i} <= s ? 2'h2 : 2'h1;
        t_pin = cyc;
        repeat (8) @(posedge clock_i);
        {sysref_i, trigger_i} <= 2'h0;
        repeat (80) @(posedge clock_i);
    endtask

    // Notes the strobe lags expected from the force bits, then launches.
    task automatic chain(input [3:0] f, input bit s);
        qa.push_back((f[1] ? lag[1] : hw_averager_lag_i) + (f[0] ? lag[2] : hw_gperiod_lag_i) + 2);
        qo.push_back((f[2] ? lag[3] : hw_oscillator_lag_i) + 1);
        pulse(s);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Monitor: takes the oldest note whenever a response or strobe appears.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (trigger_pulse_o) begin t_trig = cyc; n_trg++; end
        if (reference_sync_o) n_ref++;
        if (oscillator_reset_o) n_rst++;
        if (averager_strobe_o) begin
            chk("averager lag", cyc - t_trig, qa.size() ? qa.pop_front() : 999);
        end
        if (oscillator_strobe_o) begin
            chk("oscillator lag", cyc - t_trig, qo.size() ? qo.pop_front() : 999);
        end
        if (s_axi_bvalid_o && s_axi_bready_i) chk("bresp", s_axi_bresp_o, qb.pop_front());
        if (s_axi_rvalid_o && s_axi_rready_i) begin
            chk("rdata", s_axi_rdata_o, qr[0][31:0]);
            chk("rresp", s_axi_rresp_o, qr.pop_front() >> 32);
        end
    end

    // Watchdog; a hang counts as a mismatch.
    initial begin
        repeat (6000) @(posedge clock_i);
        mismatches++;
        results;
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(32'h490D32A9));
        {sysref_i, trigger_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 5'h00;
        {s_axi_arvalid_i, s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 66'h0;
        s_axi_wstrb_i = 4'hF;
        hw_trigger_lag_i = 8'($urandom % 16); hw_averager_lag_i = 8'($urandom % 16);
        hw_gperiod_lag_i = 8'($urandom % 16); hw_oscillator_lag_i = 8'($urandom % 16);
        rst_i = 1'b1;
        repeat (20) @(posedge clock_i);
        rst_i <= 1'b0;
        // Reset value, then a random word, of each writable register; only live bits stay.
        for (i = 0; i < 7; i++) begin
            rd(ba(tix[i]), tix[i] == 12'hE26 ? 32'h0E : 32'h0, `RESP_OKAY);
            d = $urandom;
            wr(ba(tix[i]), d, `RESP_OKAY);
            rd(ba(tix[i]), {24'h0, d[7:0] & tmk[i]}, `RESP_OKAY);
        end
        // The computed lag is read-only; refused addresses answer SLVERR.
        rd(ba(12'hE21), hw_trigger_lag_i, `RESP_OKAY);
        wr(ba(12'hE21), $urandom, `RESP_OKAY);
        rd(ba(12'hE21), hw_trigger_lag_i, `RESP_OKAY);
        rd(ba(12'hE22), 32'h0, `RESP_SLVERR);
        rd(16'hF898, 32'h0, `RESP_SLVERR);
        wr(ba(12'hE29), $urandom, `RESP_SLVERR);
        // Own trigger, every lag forced, oscillator reset and auto increment on.
        for (i = 0; i < 4; i++) lag[i] = 8'($urandom % 8);
        for (i = 0; i < 4; i++) wr(ba(i ? 12'hE25 + i : 12'hE20), lag[i], `RESP_OKAY);
        wr(ba(12'hE24), 32'h15, `RESP_OKAY);
        wr(ba(12'hE30), 32'h0F, `RESP_OKAY);
        chain(4'hF, 1'b0);
        d0 = t_trig - t_pin;
        lag[0] = lag[0] + 8'h03;
        wr(ba(12'hE20), lag[0], `RESP_OKAY);
        chain(4'hF, 1'b0);
        chk("trigger lag step", t_trig - t_pin, d0 + 3);
        rd(ba(12'hE21), hw_trigger_lag_i + 2, `RESP_OKAY);
        // Computed lags once force bits clear; reference pin ignored.
        wr(ba(12'hE24), 32'h01, `RESP_OKAY);
        wr(ba(12'hE30), 32'h00, `RESP_OKAY);
        chain(4'h0, 1'b0);
        pulse(1'b1);
        // Reference mode: reference pin resyncs, trigger pin ignored.
        wr(ba(12'hE24), 32'h00, `RESP_OKAY);
        pulse(1'b1);
        pulse(1'b0);
        // Reused reference as trigger, then as plain reference.
        wr(ba(12'hE25), 32'h01, `RESP_OKAY);
        wr(ba(12'hE24), 32'h02, `RESP_OKAY);
        chain(4'h0, 1'b1);
        wr(ba(12'hE25), 32'h00, `RESP_OKAY);
        pulse(1'b1);
        // Direct pulse mode: trigger, averager and oscillator strobes together, no lags.
        wr(ba(12'hE24), 32'h03, `RESP_OKAY);
        qa.push_back(0);
        qo.push_back(0);
        pulse(1'b0);
        chk("trigger count", n_trg, 5);
        chk("reference count", n_ref, 2);
        chk("oscillator resets", n_rst, 2);
        chk("pending strobes", qa.size() + qo.size(), 0);
        results;
    end
endmodule
